// *** verilog/metering_front_end_dsp.sv ***
// metering front end: gating, decimation, bias removal, dc extraction, dc block, gain, phase delay
// Behaviour
// - one channel routed through delay chain, length set by 8-bit unsigned amount
// - phase correction off after reset, active only when enable bit set
// - select bit one delays voltage, zero delays current, resets zero
// - each amount count is one delay step, roughly 0.0055 degree
// - step size scales with metering clock selection, finer at faster clock; here clock select leaves one step at one decimated sample (1024 clocks)
// - single-bit modulator stream decimated into raw waveform per channel
// - software bias subtracted from raw waveform, registers 0x0123 and 0x0124
// - low-pass extracts dc level, readable at 0x0114 and 0x0115
// - dc level registers are signed 32-bit two's complement
// - fast clock: dc level refreshed every 160 ms
// - slow clock: dc level refreshed every 640 ms
// - high-pass removes dc by default, bypass bit skips it
// - current processed signal forwarded to current detection output
// - current gate bit passes stream, cleared injects constant zero
// - voltage gate bit passes stream, cleared injects constant zero
// - gain stage after high-pass scales by power of two, 1/32 to 32
// - gain codes 1-5 attenuate by halving, 9-13 amplify by doubling, codes 0 and 8 are unity
// - voltage gain low nibble decodes same way, both reset to unity
// - modulator sampled at one quarter of metering clock by default
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
module metering_front_end_dsp #(
  parameter int DC_FAST_CYC = metering_dsp_pkg::DC_REFRESH_FAST_CYC,
  parameter int DC_SLOW_CYC = metering_dsp_pkg::DC_REFRESH_SLOW_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_current_bit,
  input  wire logic        i_voltage_bit,
  input  wire logic [17:0] i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic      [31:0] o_current_wave,
  output logic      [31:0] o_voltage_wave,
  output logic             o_wave_valid,
  output logic      [31:0] o_current_detect
);
  // register file
  logic [31:0] config_reg;
  logic [31:0] bias_reg [2];
  logic        clksel_reg;
  logic [31:0] dc_level_reg [2];
  logic [31:0] readdata_reg;
  logic        ack_reg;

  wire  [15:0] word_index = i_address[17:2];
  wire         access     = (i_read | i_write) & ~ack_reg;
  wire         hit_cfg    = (word_index == metering_dsp_pkg::IDX_PATH_CONFIG);
  wire         hit_bias_i = (word_index == metering_dsp_pkg::IDX_CURRENT_BIAS);
  wire         hit_bias_u = (word_index == metering_dsp_pkg::IDX_VOLTAGE_BIAS);
  wire         hit_clk    = (word_index == metering_dsp_pkg::IDX_CLOCK_SELECT);
  wire         hit_dc_i   = (word_index == metering_dsp_pkg::IDX_CURRENT_DC_LEVEL);
  wire         hit_dc_u   = (word_index == metering_dsp_pkg::IDX_VOLTAGE_DC_LEVEL);
  wire  [31:0] be_mask    = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}}, {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  // a write lands at the edge where the master sees waitrequest low, with the request still held
  wire         wr_go      = ack_reg & i_write;

  // unmapped reads return zero, unmapped writes are dropped
  wire  [31:0] read_mux   = hit_cfg    ? config_reg :
                            hit_bias_i ? bias_reg[0] :
                            hit_bias_u ? bias_reg[1] :
                            hit_clk    ? {30'h0, clksel_reg, 1'h0} :
                            hit_dc_i   ? dc_level_reg[0] :
                            hit_dc_u   ? dc_level_reg[1] : 32'h0000_0000;

  // one wait cycle per access, answer at second edge
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg      <= access;
      readdata_reg <= read_mux;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      config_reg  <= metering_dsp_pkg::RST_PATH_CONFIG;
      bias_reg[0] <= metering_dsp_pkg::RST_BIAS;
      bias_reg[1] <= metering_dsp_pkg::RST_BIAS;
      clksel_reg  <= metering_dsp_pkg::RST_CLOCK_SELECT;
    end else if (wr_go) begin
      if (hit_cfg)    config_reg  <= (config_reg & ~be_mask) | (i_writedata & be_mask);
      if (hit_bias_i) bias_reg[0] <= (bias_reg[0] & ~be_mask) | (i_writedata & be_mask);
      if (hit_bias_u) bias_reg[1] <= (bias_reg[1] & ~be_mask) | (i_writedata & be_mask);
      if (hit_clk && i_byteenable[0]) clksel_reg <= i_writedata[metering_dsp_pkg::POS_CLOCK_SELECT];
    end
  end

  assign o_readdata    = readdata_reg;
  // waitrequest high until the answer cycle; registered from ~access, so it always equals ~ack_reg
  logic wait_reg;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) wait_reg <= 1'b1;
    else          wait_reg <= ~access;
  end
  assign o_waitrequest = wait_reg;

  // config fields
  wire       bypass_hpf  = config_reg[metering_dsp_pkg::POS_DC_BLOCK_BYPASS];
  wire       phase_en    = config_reg[metering_dsp_pkg::POS_PHASE_CORR_ENABLE];
  wire       phase_sel_u = config_reg[metering_dsp_pkg::POS_PHASE_DELAY_SEL];
  wire [7:0] phase_amt   = config_reg[metering_dsp_pkg::POS_PHASE_AMOUNT_LO +: 8];
  wire [1:0] gate        = {config_reg[metering_dsp_pkg::POS_VOLTAGE_GATE],
                            config_reg[metering_dsp_pkg::POS_CURRENT_GATE]};
  wire [3:0] gain_code [2];
  assign gain_code[0] = config_reg[metering_dsp_pkg::POS_CURRENT_GAIN_LO +: 4];
  assign gain_code[1] = config_reg[metering_dsp_pkg::POS_VOLTAGE_GAIN_LO +: 4];

  // sample strobe at a quarter of the clock
  logic [1:0] div_reg;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) div_reg <= 2'h0;
    else          div_reg <= div_reg + 2'h1;
  end
  wire samp = (div_reg == 2'(metering_dsp_pkg::SAMPLE_DIV - 1));

  logic [metering_dsp_pkg::DECIM_LOG2-1:0] dec_cnt_reg;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n)  dec_cnt_reg <= '0;
    else if (samp) dec_cnt_reg <= dec_cnt_reg + 1'b1;
  end
  wire dec_done = samp & (&dec_cnt_reg);

  // refresh timer; clock select picks the slower period
  logic [31:0] dc_tmr_reg;
  wire  [31:0] dc_period = clksel_reg ? 32'(DC_SLOW_CYC) : 32'(DC_FAST_CYC);
  wire         dc_tick   = (dc_tmr_reg >= dc_period - 32'h1);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n)     dc_tmr_reg <= 32'h0;
    else if (dc_tick) dc_tmr_reg <= 32'h0;
    else              dc_tmr_reg <= dc_tmr_reg + 32'h1;
  end

  wire        bit_in [2];
  assign bit_in[0] = i_current_bit;
  assign bit_in[1] = i_voltage_bit;
  logic [31:0] gained [2];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [31:0] acc_reg;
      logic [31:0] raw_reg;
      logic [31:0] lpf_reg;
      logic [31:0] hpf_reg;
      logic [31:0] gain_reg;
      // gated zero injects a zero-mean stream (+1 or -1 alternating is avoided: counts zero)
      wire        gated   = gate[ch] & bit_in[ch];
      wire [31:0] step    = gate[ch] ? (gated ? 32'h1 : 32'hffff_ffff) : 32'h0;
      wire [31:0] unbias  = raw_reg - bias_reg[ch];
      wire [31:0] hp_out  = unbias - hpf_reg;
      wire [31:0] ac_sig  = bypass_hpf ? unbias : hp_out;
      wire [3:0]  gc      = gain_code[ch];
      wire        att_ok  = (gc <= metering_dsp_pkg::GAIN_ATTEN_MAX);
      wire        amp_ok  = (gc >= metering_dsp_pkg::GAIN_BOOST_BASE) && (gc <= metering_dsp_pkg::GAIN_BOOST_MAX);
      wire [2:0]  sh      = gc[2:0];
      wire [31:0] scaled  = att_ok ? 32'($signed(ac_sig) >>> sh) :
                            amp_ok ? (ac_sig << sh) : ac_sig;
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          acc_reg  <= 32'h0;
          raw_reg  <= 32'h0;
          lpf_reg  <= 32'h0;
          hpf_reg  <= 32'h0;
          gain_reg <= 32'h0;
        end else begin
          if (samp) acc_reg <= dec_done ? 32'h0 : acc_reg + step;
          if (dec_done) begin
            raw_reg  <= acc_reg + step;
            lpf_reg  <= lpf_reg + 32'($signed(unbias - lpf_reg) >>> metering_dsp_pkg::DC_LPF_SHIFT);
            hpf_reg  <= hpf_reg + 32'($signed(hp_out) >>> metering_dsp_pkg::HPF_SHIFT);
            gain_reg <= scaled;
          end
        end
      end
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n)     dc_level_reg[ch] <= 32'h0;
        else if (dc_tick) dc_level_reg[ch] <= lpf_reg;
      end
      assign gained[ch] = gain_reg;
    end
  endgenerate

  // delay line, one tap per decimated sample; each tap is one phase step
  logic [31:0] delay_mem [metering_dsp_pkg::PHASE_DEPTH];
  logic [7:0]  wr_ptr_reg;
  logic        dec_dly_reg;
  wire  [31:0] delay_in  = phase_sel_u ? gained[1] : gained[0];
  wire  [31:0] delay_out = delay_mem[8'(wr_ptr_reg - phase_amt)];
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wr_ptr_reg  <= 8'h0;
      dec_dly_reg <= 1'b0;
    end else begin
      dec_dly_reg <= dec_done;
      if (dec_dly_reg) wr_ptr_reg <= wr_ptr_reg + 8'h1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (dec_dly_reg) delay_mem[wr_ptr_reg] <= delay_in;
  end
  // amount zero reads the sample just written, i.e. no delay
  wire [31:0] delayed = (phase_amt == 8'h0) ? delay_in : delay_out;
  wire [31:0] i_out   = (phase_en && !phase_sel_u) ? delayed : gained[0];
  wire [31:0] u_out   = (phase_en &&  phase_sel_u) ? delayed : gained[1];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_current_wave   <= 32'h0;
      o_voltage_wave   <= 32'h0;
      o_current_detect <= 32'h0;
      o_wave_valid     <= 1'b0;
    end else begin
      o_wave_valid <= dec_dly_reg;
      if (dec_dly_reg) begin
        o_current_wave   <= i_out;
        o_voltage_wave   <= u_out;
        o_current_detect <= gained[0];
      end
    end
  end

  a_gate_zero_current: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!gate[0] && samp && !dec_done) |=> (g_chan[0].acc_reg == $past(g_chan[0].acc_reg)))
    else $error("current gate off but stream counted");
  a_gate_zero_voltage: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!gate[1] && samp && !dec_done) |=> (g_chan[1].acc_reg == $past(g_chan[1].acc_reg)))
    else $error("voltage gate off but stream counted");
  a_phase_off_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (dec_dly_reg && !phase_en) |=> (o_current_wave == $past(gained[0]))) else $error("current delayed while disabled");
  a_dc_level_update: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    dc_tick |=> (dc_level_reg[0] == $past(g_chan[0].lpf_reg))) else $error("dc level not refreshed");
  a_dc_level_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!dc_tick && !$past(dc_tick)) |-> $stable(dc_level_reg[1])) else $error("dc level changed off tick");
  a_unity_gain: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (gain_code[0] == 4'h6 || gain_code[0] == 4'hf) |-> (g_chan[0].scaled == g_chan[0].ac_sig))
    else $error("undefined gain not unity");
  a_bypass_hpf: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    bypass_hpf |-> (g_chan[1].ac_sig == g_chan[1].unbias)) else $error("bypass did not skip filter");
  a_bus_answer: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    access |=> (!o_waitrequest ##1 o_waitrequest)) else $error("bus answer late");
  a_wait_one_cycle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !o_waitrequest |=> o_waitrequest) else $error("waitrequest low too long");
  a_detect_feed: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    dec_dly_reg |=> (o_current_detect == $past(gained[0]))) else $error("detect path not fed");
  a_phase_sel_volt: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (dec_dly_reg && phase_en && phase_sel_u) |=> (o_current_wave == $past(gained[0])))
    else $error("current delayed while voltage selected");
  a_phase_ptr_step: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    dec_dly_reg |=> (wr_ptr_reg == $past(wr_ptr_reg) + 8'h1)) else $error("delay pointer did not advance");
  a_wave_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_wave_valid |=> !o_wave_valid) else $error("sample strobe longer than one cycle");
  a_gain_boost_top: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (gain_code[1] == metering_dsp_pkg::GAIN_BOOST_MAX) |-> (g_chan[1].scaled == (g_chan[1].ac_sig << 3'h5)))
    else $error("top boost code not x32");
  a_gain_atten_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (gain_code[0] == metering_dsp_pkg::GAIN_ATTEN_MAX) |-> (g_chan[0].scaled == 32'($signed(g_chan[0].ac_sig) >>> 3'h5)))
    else $error("lowest code not x1/32");
endmodule

// *** verilog/metering_dsp_pkg.sv ***
// package: register map, field positions, timing constants of the metering front end
package metering_dsp_pkg;
  // word indices as printed; byte address = 4 * index
  localparam logic [15:0] IDX_CURRENT_DC_LEVEL  = 16'h0114;
  localparam logic [15:0] IDX_VOLTAGE_DC_LEVEL  = 16'h0115;
  localparam logic [15:0] IDX_CURRENT_BIAS      = 16'h0123;
  localparam logic [15:0] IDX_VOLTAGE_BIAS      = 16'h0124;
  localparam logic [15:0] IDX_PATH_CONFIG       = 16'h0184;
  localparam logic [15:0] IDX_CLOCK_SELECT      = 16'h0180;
  // config field positions
  localparam int          POS_DC_BLOCK_BYPASS   = 20;
  localparam int          POS_PHASE_CORR_ENABLE = 19;
  localparam int          POS_PHASE_DELAY_SEL   = 18;
  localparam int          POS_CURRENT_GATE      = 17;
  localparam int          POS_VOLTAGE_GATE      = 16;
  localparam int          POS_PHASE_AMOUNT_LO   = 8;
  localparam int          POS_CURRENT_GAIN_LO   = 4;
  localparam int          POS_VOLTAGE_GAIN_LO   = 0;
  localparam int          POS_CLOCK_SELECT      = 1;
  localparam logic [31:0] RST_PATH_CONFIG       = 32'h0000_0000;
  localparam logic [31:0] RST_BIAS              = 32'h0000_0000;
  localparam logic        RST_CLOCK_SELECT      = 1'h0;
  // gain codes
  localparam logic [3:0]  GAIN_ATTEN_MAX        = 4'h5;
  localparam logic [3:0]  GAIN_BOOST_BASE       = 4'h8;
  localparam logic [3:0]  GAIN_BOOST_MAX        = 4'hd;
  // sample strobe: one modulator bit per 4 metering clocks
  localparam int          SAMPLE_DIV            = 4;
  // decimation: 256 modulator bits per output sample
  localparam int          DECIM_LOG2            = 8;
  // dc refresh period per metering clock selection
  localparam int          DC_REFRESH_FAST_MS    = 160;
  localparam int          DC_REFRESH_SLOW_MS    = 640;
  localparam int          CLOCK_HZ              = 10_000_000;
  localparam int          DC_REFRESH_FAST_CYC   = (DC_REFRESH_FAST_MS * (CLOCK_HZ / 1000));
  localparam int          DC_REFRESH_SLOW_CYC   = (DC_REFRESH_SLOW_MS * (CLOCK_HZ / 1000));
  // dc extraction and dc block filter shifts, phase delay depth
  localparam int          DC_LPF_SHIFT          = 6;
  localparam int          HPF_SHIFT             = 8;
  localparam int          PHASE_DEPTH           = 256;
endpackage

// *** tb/sigma_delta_source.sv ***
// partner: two single-bit modulator streams feeding the front end
`timescale 1ns/10ps
module sigma_delta_source #(
  parameter int ONES_IN_FOUR = 3
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  output logic      o_current_bit,
  output logic      o_voltage_bit
);
  // new bit every edge; the design samples one in four a biased mean keeps the output off zero
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_current_bit <= 1'b0;
      o_voltage_bit <= 1'b0;
    end else begin
      o_current_bit <= (($urandom % 4) < ONES_IN_FOUR);
      o_voltage_bit <= (($urandom % 4) < ONES_IN_FOUR);
    end
  end
endmodule

// *** tb/metering_front_end_dsp_test.sv ***
// testbench: registers, input gates and digital gain of the metering front end
`timescale 1ns/10ps
module metering_front_end_dsp_test;
  // about 76 decimated samples of 1024 clocks each, plus margin
  localparam int CEIL = 95000;
  logic        mclk, rst_n, cur_bit, volt_bit, rd, wr, waitreq, wave_valid;
  logic [17:0] addr;
  logic [31:0] wdata, rdata, cur_wave, volt_wave, detect, ref_w, d;
  logic [3:0]  be;
  logic [31:0] regs [int];
  logic [15:0] idx_list [6] = '{16'h0114, 16'h0115, 16'h0123, 16'h0124, 16'h0184, 16'h0180};
  int          err_total, n_compared, cyc;
  int          amt;
  logic [31:0] hist [$];
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  sigma_delta_source src_u (.i_mclk(mclk), .i_rst_n(rst_n), .o_current_bit(cur_bit), .o_voltage_bit(volt_bit));
  metering_front_end_dsp #(.DC_FAST_CYC(2000), .DC_SLOW_CYC(8000)) dut_u (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_current_bit(cur_bit), .i_voltage_bit(volt_bit),
    .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(be),
    .o_readdata(rdata), .o_waitrequest(waitreq), .o_current_wave(cur_wave),
    .o_voltage_wave(volt_wave), .o_wave_valid(wave_valid), .o_current_detect(detect));
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == CEIL) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is seen low; the wait is open ended apart from the run ceiling
  task automatic bus(input logic is_wr, input logic [15:0] idx, input logic [31:0] v, input logic [3:0] lanes,
                     output logic [31:0] q);
    @(posedge mclk);
    addr <= {idx, 2'b00};
    wdata <= v;
    be <= lanes;
    rd <= ~is_wr;
    wr <= is_wr;
    do @(posedge mclk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic reg_wr(input logic [15:0] idx, input logic [31:0] v, input logic [3:0] lanes);
    logic [31:0] q;
    bus(1'b1, idx, v, lanes, q);
    // dc level words take no writes
    if (regs.exists(idx) && idx[15:4] != 12'h011)
      for (int b = 0; b < 4; b++) if (lanes[b]) regs[idx][8*b +: 8] = v[8*b +: 8];
  endtask
  task automatic reg_chk(input logic [15:0] idx, input logic [31:0] mask);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0000_0000, 4'hf, q);
    check(q & mask, (regs.exists(idx) ? regs[idx] : 32'h0000_0000) & mask);
  endtask
  task automatic wait_samples(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (wave_valid !== 1'b1 && k < 1100);
      if (i > 0) check(32'(k), 32'h0000_0400);
      else if (k >= 1100) err_total++;
    end
  endtask
  function automatic logic [31:0] gained(input logic [31:0] r, input logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h5) return $signed(r) >>> c;
    if (c >= 4'h9 && c <= 4'hd) return r << (c - 4'h8);
    return r;
  endfunction
  // dc extraction from a cleared state with constant input zero minus bias b
  function automatic logic [31:0] dc_model(input int cnt, input logic [31:0] b);
    logic [31:0] l;
    l = 32'h0000_0000;
    for (int k = 0; k < cnt; k++) l = l + 32'($signed(32'h0000_0000 - b - l) >>> metering_dsp_pkg::DC_LPF_SHIFT);
    return l;
  endfunction
  initial begin
    void'($urandom(22760));
    rst_n = 1'b0;
    {rd, wr, addr, wdata, be} = '0;
    foreach (idx_list[i]) regs[idx_list[i]] = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (idx_list[i]) reg_chk(idx_list[i], 32'hffff_ffff);
    reg_wr(metering_dsp_pkg::IDX_CURRENT_DC_LEVEL, 32'hffff_ffff, 4'hf);
    reg_chk(metering_dsp_pkg::IDX_CURRENT_DC_LEVEL, 32'hffff_ffff);
    reg_chk(16'h0100, 32'hffff_ffff);
    d = $urandom;
    reg_wr(metering_dsp_pkg::IDX_VOLTAGE_BIAS, d, 4'h5);
    reg_chk(metering_dsp_pkg::IDX_VOLTAGE_BIAS, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) begin
      reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, $urandom & 32'h001f_ffff, 4'hf);
      reg_chk(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h001f_ffff);
    end
    // small bias so the x32 code stays far from overflow
    reg_wr(metering_dsp_pkg::IDX_CURRENT_BIAS, 32'h0000_0100, 4'hf);
    reg_wr(metering_dsp_pkg::IDX_VOLTAGE_BIAS, 32'h0000_0100, 4'hf);
    reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h0010_0000, 4'hf);
    wait_samples(4);
    ref_w = cur_wave;
    check(ref_w, 32'h0000_0000 - 32'h0000_0100);
    check(volt_wave, 32'h0000_0000 - 32'h0000_0100);
    for (int c = 0; c < 16; c++) begin
      reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h0010_0000 | (c << 4) | c, 4'hf);
      wait_samples(2);
      check(cur_wave, gained(ref_w, 4'(c)));
      check(volt_wave, gained(ref_w, 4'(c)));
      check(detect, gained(ref_w, 4'(c)));
    end
    reg_wr(metering_dsp_pkg::IDX_CURRENT_BIAS, 32'h0000_0000, 4'hf);
    reg_wr(metering_dsp_pkg::IDX_VOLTAGE_BIAS, 32'h0000_0000, 4'hf);
    reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h0012_0000, 4'hf);
    wait_samples(4);
    check({31'h0, cur_wave != 32'h0}, 32'h0000_0001);
    check(volt_wave, 32'h0000_0000);
    reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h0011_0000, 4'hf);
    wait_samples(4);
    check({31'h0, volt_wave != 32'h0}, 32'h0000_0001);
    check(cur_wave, 32'h0000_0000);
    // delay the current by a random amount; the detect output is the undelayed reference
    amt = 1 + ($urandom % 4);
    reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h001b_0000 | (amt << 8), 4'hf);
    wait_samples(2);
    for (int j = 0; j < amt + 3; j++) begin
      wait_samples(1);
      hist.push_back(detect);
      if (hist.size() > amt) check(cur_wave, hist[hist.size() - 1 - amt]);
    end
    reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h001f_0000 | (amt << 8), 4'hf);
    wait_samples(2);
    check(cur_wave, detect);
    reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h0013_0000 | (amt << 8), 4'hf);
    wait_samples(2);
    check(cur_wave, detect);
    // dc block on, gates off: a constant input decays by the filter step each sample
    reg_wr(metering_dsp_pkg::IDX_CURRENT_BIAS, 32'h0000_1000, 4'hf);
    reg_wr(metering_dsp_pkg::IDX_VOLTAGE_BIAS, 32'h0000_1000, 4'hf);
    reg_wr(metering_dsp_pkg::IDX_PATH_CONFIG, 32'h0000_0000, 4'hf);
    wait_samples(4);
    ref_w = cur_wave;
    d = volt_wave;
    repeat (2) begin
      wait_samples(1);
      check(cur_wave, ref_w - 32'($signed(ref_w) >>> metering_dsp_pkg::HPF_SHIFT));
      check(volt_wave, d - 32'($signed(d) >>> metering_dsp_pkg::HPF_SHIFT));
      ref_w = cur_wave;
      d = volt_wave;
    end
    // second reset clears the dc extraction, so its level follows a known recursion
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (idx_list[i]) regs[idx_list[i]] = 32'h0000_0000;
    @(posedge mclk);
    check({31'h0, waitreq}, 32'h0000_0001);
    check(cur_wave, 32'h0000_0000);
    reg_wr(metering_dsp_pkg::IDX_CURRENT_BIAS, 32'h0000_4000, 4'hf);
    reg_wr(metering_dsp_pkg::IDX_VOLTAGE_BIAS, 32'h0000_4000, 4'hf);
    wait_samples(4);
    bus(1'b0, metering_dsp_pkg::IDX_CURRENT_DC_LEVEL, 32'h0000_0000, 4'hf, d);
    check(d, dc_model(3, 32'h0000_4000));
    bus(1'b0, metering_dsp_pkg::IDX_VOLTAGE_DC_LEVEL, 32'h0000_0000, 4'hf, d);
    check(d, dc_model(3, 32'h0000_4000));
    reg_wr(metering_dsp_pkg::IDX_CLOCK_SELECT, 32'h0000_0002, 4'hf);
    wait_samples(2);
    bus(1'b0, metering_dsp_pkg::IDX_CURRENT_DC_LEVEL, 32'h0000_0000, 4'hf, d);
    check(d, dc_model(3, 32'h0000_4000));
    wait_samples(6);
    bus(1'b0, metering_dsp_pkg::IDX_CURRENT_DC_LEVEL, 32'h0000_0000, 4'hf, d);
    check(d, dc_model(11, 32'h0000_4000));
    print_verdict();
  end
endmodule
